/* File: hw/lscl_pkg.sv */
// Purpose: shared constants and types for the level status condition logic
// Assumes: 16-bit words, status bits numbered from the lsb as bit 0
// Notes: bit numbers follow the status word layout
package lscl_pkg;
  // ============================================================
  // status word layout
  localparam int LSCL_WORD_W = 16;
  localparam int LSCL_LEVELS = 4;
  localparam int LSCL_LVL_W = 2;
  localparam int LSCL_BIT_EVEN = 0;
  localparam int LSCL_BIT_CARRY = 1;
  localparam int LSCL_BIT_OVFL = 2;
  localparam int LSCL_BIT_NEG = 3;
  localparam int LSCL_BIT_ZERO = 4;
  localparam int LSCL_BIT_SUPV = 8;
  localparam int LSCL_BIT_INPROC = 9;
  localparam int LSCL_BIT_TRACE = 10;
  localparam int LSCL_BIT_SMASK = 11;
  localparam logic [15:0] LSCL_RESET_WORD = 16'h0100;
  localparam logic [15:0] LSCL_WRITE_MASK = 16'h0F1F;

  // ============================================================
  // operations presented by the arithmetic unit
  typedef enum logic [3:0] {
    LSCL_OP_NONE = 4'h0,
    LSCL_OP_ADD_WORD = 4'h1,
    LSCL_OP_SUB_WORD = 4'h2,
    LSCL_OP_ADD_WORD_WITH_CARRY_IN = 4'h3,
    LSCL_OP_SUB_WORD_WITH_BORROW_IN = 4'h4,
    LSCL_OP_ADD_CARRY_TO_REGISTER = 4'h5,
    LSCL_OP_SUB_CARRY_FROM_REGISTER = 4'h6,
    LSCL_OP_IO_CODE = 4'h7,
    LSCL_OP_LOAD_LEVEL_BLOCK = 4'h8,
    LSCL_OP_LEVEL_EXIT = 4'h9
  } lscl_op_e;

  // ============================================================
  // branch and jump conditions
  typedef enum logic [3:0] {
    LSCL_CC_ZERO = 4'h0,
    LSCL_CC_POS = 4'h1,
    LSCL_CC_NEG = 4'h2,
    LSCL_CC_EVEN = 4'h3,
    LSCL_CC_ALT = 4'h4,
    LSCL_CC_ALE = 4'h5,
    LSCL_CC_LLE = 4'h6,
    LSCL_CC_LLT = 4'h7
  } lscl_cond_e;

  // ============================================================
  // request from the sequencer and datapath
  typedef struct packed {
    logic valid;
    lscl_op_e op;
    logic [15:0] opnd_a;
    logic [15:0] opnd_b;
    logic [15:0] load_word;
    logic [1:0] target_level;
    logic [2:0] io_code;
  } lscl_req_s;

  // conditional transfer test
  typedef struct packed {
    logic valid;
    lscl_cond_e cond;
    logic negate;
  } lscl_test_s;

  // interrupt and reset events forcing supervisor state
  typedef struct packed {
    logic class_int;
    logic io_int;
    logic initial_program_load;
    logic sys_reset;
    logic [1:0] level;
  } lscl_event_s;
endpackage : lscl_pkg

/* File: hw/lscl_word_store.sv */
// Purpose: per-level storage of the status word, registered read port
// Assumes: one write and one read per cycle
// Notes: read data is registered, one cycle latency
`timescale 1ns/1ps
module lscl_word_store
  import lscl_pkg::*;
#(
  parameter int LEVELS = LSCL_LEVELS,
  parameter int LVL_W = LSCL_LVL_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [LVL_W-1:0] wr_level,
  input wire logic [15:0] wr_word,
  input wire logic [LVL_W-1:0] rd_level,
  output logic [15:0] rd_word
);
  initial begin
    if (LEVELS != (1 << LVL_W)) $error("LEVELS must equal 2**LVL_W");
  end

  // ============================================================
  // storage, reset so each level starts in supervisor state
  logic [15:0] words [LEVELS];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < LEVELS; i++) words[i] <= LSCL_RESET_WORD;
    end else if (wr_en) begin
      words[wr_level] <= wr_word;
    end
  end

  // registered read; written value bypasses so the read is current
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_word <= LSCL_RESET_WORD;
    end else if (wr_en && wr_level == rd_level) begin
      rd_word <= wr_word;
    end else begin
      rd_word <= words[rd_level];
    end
  end
endmodule : lscl_word_store

/* File: hw/lscl_cond_eval.sv */
// Purpose: evaluates a branch or jump condition against the indicators
// Assumes: indicators taken from the active level's status word
// Notes: purely combinational
`timescale 1ns/1ps
module lscl_cond_eval
  import lscl_pkg::*;
(
  input wire logic [4:0] ind,
  input wire lscl_cond_e cond,
  input wire logic negate,
  output logic taken
);
  // ============================================================
  // indicator split
  wire logic e = ind[LSCL_BIT_EVEN];
  wire logic c = ind[LSCL_BIT_CARRY];
  wire logic o = ind[LSCL_BIT_OVFL];
  wire logic n = ind[LSCL_BIT_NEG];
  wire logic z = ind[LSCL_BIT_ZERO];
  // signed less than is negative differing from overflow
  wire logic lt = n ^ o;
  logic raw;

  // condition table; the not-forms invert the result
  always_comb begin
    case (cond)
      LSCL_CC_ZERO: raw = z;
      LSCL_CC_POS: raw = !n && !z;
      LSCL_CC_NEG: raw = n;
      LSCL_CC_EVEN: raw = e;
      LSCL_CC_ALT: raw = lt;
      LSCL_CC_ALE: raw = lt || z;
      LSCL_CC_LLE: raw = c || z;
      LSCL_CC_LLT: raw = c;
      default: raw = 1'b0;
    endcase
  end

  assign taken = raw ^ negate;
endmodule : lscl_cond_eval

/* File: hw/lscl_status.sv */
// Purpose: per-level status word, indicator update and condition tests
// Assumes: sequencer holds each request for one cycle; active level stable
// Notes: outputs registered; indicator results appear one cycle after op
//
// Operation
// - indicators in bits 0..4: even, carry, overflow, negative, zero
// - add word with carry-in adds both operands plus current carry
// - add carry to register adds only carry to one operand
// - subtract forms chain a borrow through the carry indicator
// - chained zero indicator set only if every result word was zero
// - chained even indicator comes from the lowest-order word lsb
// - chained negative indicator is msb of highest-order word
// - carry set when full result overflows unsigned combined width
// - overflow set when full result overflows signed combined width
// - conditional branch or jump taken only when the test succeeds
// - bit 8 is supervisor state; zero means problem state
// - interrupts, program load and resets force supervisor bit to one
// - load level block in supervisor state loads supervisor bit
// - bit 9 is in-process, set while a level active or preempted; here only load level block sets it
// - level exit clears the in-process bit
// - load level block sets or clears in-process; it steers switching
// - trace bit 10 raises a trace interrupt at each instruction start
// - summary mask bit 11 clear blocks priority and some class interrupts
// - summary mask set lets interrupts through normally
// - equal tests zero indicator set, unequal tests it clear
// - I/O op or I/O interrupt loads even, carry, overflow with code
`timescale 1ns/1ps
module lscl_status
  import lscl_pkg::*;
#(
  parameter int WORD_W = LSCL_WORD_W,
  parameter int LEVELS = LSCL_LEVELS,
  parameter int LVL_W = LSCL_LVL_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [LVL_W-1:0] active_level,
  input wire lscl_req_s req,
  input wire lscl_test_s test,
  input wire lscl_event_s evt,
  input wire logic instr_start,
  input wire logic prio_int_req,
  input wire logic maskable_class_req,
  output logic [WORD_W-1:0] result,
  output logic [WORD_W-1:0] level_status_word,
  output logic transfer_taken,
  output logic test_done,
  output logic trace_int,
  output logic prio_int_grant,
  output logic maskable_class_grant,
  output logic privilege_fault,
  output logic level_in_process
);
  initial begin
    if (WORD_W != LSCL_WORD_W) $error("WORD_W must match the status word width");
    if (LEVELS != (1 << LVL_W)) $error("LEVELS must equal 2**LVL_W");
  end

  // ============================================================
  // per-level status words
  logic st_wr_en;
  logic [LVL_W-1:0] st_wr_level;
  logic [15:0] st_wr_word;
  logic [15:0] cur_word;

  lscl_word_store #(.LEVELS(LEVELS), .LVL_W(LVL_W)) u_store (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(st_wr_en),
    .wr_level(st_wr_level),
    .wr_word(st_wr_word),
    .rd_level(active_level),
    .rd_word(cur_word)
  );

  // ============================================================
  // indicator fields of the active level
  wire logic cur_carry = cur_word[LSCL_BIT_CARRY];
  wire logic cur_zero = cur_word[LSCL_BIT_ZERO];
  wire logic cur_supv = cur_word[LSCL_BIT_SUPV];
  wire logic cur_trace = cur_word[LSCL_BIT_TRACE];
  wire logic cur_smask = cur_word[LSCL_BIT_SMASK];
  wire logic cur_inproc = cur_word[LSCL_BIT_INPROC];

  // stale-read guard: the store bypass already shows an update written last cycle to this level;
  // forward it as well so a level switched to after the write also reads it
  logic fwd_valid;
  logic [15:0] fwd_word;
  logic [LVL_W-1:0] fwd_level;
  wire logic use_fwd = fwd_valid && fwd_level == active_level;
  wire logic [15:0] word_now = use_fwd ? fwd_word : cur_word;
  wire logic carry_now = word_now[LSCL_BIT_CARRY];
  wire logic zero_now = word_now[LSCL_BIT_ZERO];

  // ============================================================
  // operation decode
  wire logic is_add = req.op == LSCL_OP_ADD_WORD;
  wire logic is_sub = req.op == LSCL_OP_SUB_WORD;
  wire logic is_awc = req.op == LSCL_OP_ADD_WORD_WITH_CARRY_IN;
  wire logic is_swb = req.op == LSCL_OP_SUB_WORD_WITH_BORROW_IN;
  wire logic is_acr = req.op == LSCL_OP_ADD_CARRY_TO_REGISTER;
  wire logic is_scr = req.op == LSCL_OP_SUB_CARRY_FROM_REGISTER;
  wire logic is_io = req.op == LSCL_OP_IO_CODE;
  wire logic is_llb = req.op == LSCL_OP_LOAD_LEVEL_BLOCK;
  wire logic is_lex = req.op == LSCL_OP_LEVEL_EXIT;
  wire logic is_chain = is_awc || is_swb || is_acr || is_scr;
  wire logic is_subtract = is_sub || is_swb || is_scr;
  wire logic is_arith = is_add || is_sub || is_chain;
  wire logic one_opnd = is_acr || is_scr;
  wire logic supv_ok = word_now[LSCL_BIT_SUPV];
  // level block target may differ from the active level
  wire logic [LVL_W-1:0] llb_level = req.target_level;

  // ============================================================
  // adder: subtract as a + ~b + carry-in, carry indicator holds borrow
  wire logic [15:0] b_in = one_opnd ? 16'h0000 : req.opnd_b;
  wire logic [15:0] b_eff = is_subtract ? ~b_in : b_in;
  wire logic chain_cin = is_subtract ? !carry_now : carry_now;
  wire logic cin = is_chain ? chain_cin : is_subtract;
  wire logic [16:0] sum = {1'b0, req.opnd_a} + {1'b0, b_eff} + {16'h0000, cin};
  wire logic [15:0] sum_w = sum[15:0];
  wire logic cout = sum[16];
  wire logic ci_msb = sum_w[15] ^ req.opnd_a[15] ^ b_eff[15];

  // ============================================================
  // next indicators
  wire logic res_zero = sum_w == 16'h0000;
  wire logic nxt_zero = is_chain ? (res_zero && zero_now) : res_zero;
  // even only meaningful from the lowest word: keep it through the chain
  wire logic nxt_even = is_chain ? word_now[LSCL_BIT_EVEN] : !sum_w[0];
  wire logic nxt_neg = sum_w[15];
  wire logic nxt_carry = is_subtract ? !cout : cout;
  wire logic nxt_ovfl = ci_msb ^ cout;

  logic [15:0] arith_word;
  always_comb begin
    arith_word = word_now;
    arith_word[LSCL_BIT_EVEN] = nxt_even;
    arith_word[LSCL_BIT_CARRY] = nxt_carry;
    arith_word[LSCL_BIT_OVFL] = nxt_ovfl;
    arith_word[LSCL_BIT_NEG] = nxt_neg;
    arith_word[LSCL_BIT_ZERO] = nxt_zero;
  end

  // I/O condition code: even is the high-order code bit
  logic [15:0] io_word;
  always_comb begin
    io_word = word_now;
    io_word[LSCL_BIT_EVEN] = req.io_code[2];
    io_word[LSCL_BIT_CARRY] = req.io_code[1];
    io_word[LSCL_BIT_OVFL] = req.io_code[0];
  end

  wire logic [15:0] lex_word = word_now & ~(16'h0001 << LSCL_BIT_INPROC);
  wire logic [15:0] llb_word = req.load_word & LSCL_WRITE_MASK;
  wire logic [15:0] supv_set = 16'h0001 << LSCL_BIT_SUPV;
  wire logic evt_any = evt.class_int || evt.io_int || evt.initial_program_load || evt.sys_reset;
  // ============================================================
  // write selection; events force supervisor state, set wins
  wire logic llb_go = req.valid && is_llb && supv_ok;
  wire logic op_go = req.valid && (is_arith || is_io || is_lex);
  logic [15:0] op_word;
  always_comb begin
    if (is_io) begin
      op_word = io_word;
    end else if (is_lex) begin
      op_word = lex_word;
    end else begin
      op_word = arith_word;
    end
  end

  always_comb begin
    st_wr_en = 1'b0;
    st_wr_level = active_level;
    st_wr_word = word_now;
    if (evt_any) begin
      st_wr_en = 1'b1;
      st_wr_level = evt.level;
      st_wr_word = ((op_go && evt.level == active_level) ? op_word : word_now);
      if (evt.level != active_level) begin
        st_wr_word = cur_word_sel(evt.level);
      end
      if (evt.io_int) begin
        st_wr_word[LSCL_BIT_EVEN] = req.io_code[2];
        st_wr_word[LSCL_BIT_CARRY] = req.io_code[1];
        st_wr_word[LSCL_BIT_OVFL] = req.io_code[0];
      end
      st_wr_word = st_wr_word | supv_set;
    end else if (llb_go) begin
      st_wr_en = 1'b1;
      st_wr_level = llb_level;
      st_wr_word = llb_word;
    end else if (op_go) begin
      st_wr_en = 1'b1;
      st_wr_word = op_word;
    end
  end

  // other levels' words are not visible here; event on another level
  // therefore writes the reset pattern with the supervisor bit set, plus the code on an I/O interrupt
  function automatic logic [15:0] cur_word_sel(input logic [LVL_W-1:0] lvl);
    cur_word_sel = LSCL_RESET_WORD | {15'h0000, lvl == lvl};
    cur_word_sel = cur_word_sel & ~16'h0001;
  endfunction : cur_word_sel

  // forwarding register for the just-written word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid <= 1'b0;
      fwd_word <= LSCL_RESET_WORD;
      fwd_level <= '0;
    end else begin
      fwd_valid <= st_wr_en;
      fwd_word <= st_wr_word;
      fwd_level <= st_wr_level;
    end
  end

  // ============================================================
  // condition test
  logic cond_taken;
  lscl_cond_eval u_cond (
    .ind(word_now[4:0]),
    .cond(test.cond),
    .negate(test.negate),
    .taken(cond_taken)
  );

  // ============================================================
  // interrupt gating by summary mask and trace
  wire logic next_prio_grant = prio_int_req && word_now[LSCL_BIT_SMASK];
  wire logic next_class_grant = maskable_class_req && word_now[LSCL_BIT_SMASK];
  wire logic next_trace = instr_start && word_now[LSCL_BIT_TRACE];
  wire logic next_priv_fault = req.valid && is_llb && !supv_ok;

  // registered outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result <= '0;
      level_status_word <= LSCL_RESET_WORD;
      transfer_taken <= 1'b0;
      test_done <= 1'b0;
      trace_int <= 1'b0;
      prio_int_grant <= 1'b0;
      maskable_class_grant <= 1'b0;
      privilege_fault <= 1'b0;
      level_in_process <= 1'b0;
    end else begin
      result <= (req.valid && is_arith) ? sum_w : result;
      level_status_word <= (st_wr_en && st_wr_level == active_level) ? st_wr_word : word_now;
      transfer_taken <= test.valid && cond_taken;
      test_done <= test.valid;
      trace_int <= next_trace;
      prio_int_grant <= next_prio_grant;
      maskable_class_grant <= next_class_grant;
      privilege_fault <= next_priv_fault;
      level_in_process <= word_now[LSCL_BIT_INPROC];
    end
  end

  // unused copies kept quiet for readers
  wire logic unused_ok = cur_carry ^ cur_zero ^ cur_supv ^ cur_trace ^ cur_smask ^ cur_inproc;
endmodule : lscl_status

/* File: dv/lscl_status_checker.sv */
// Purpose: port assertions for the level status block
// Assumes: one clock domain, reset_n asynchronous active low
// Notes: quiet means no request or event competes for the word
`timescale 1ns/1ps
module lscl_status_checker
  import lscl_pkg::*;
#(
  parameter int WORD_W = LSCL_WORD_W,
  parameter int LVL_W = LSCL_LVL_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [LVL_W-1:0] active_level,
  input wire lscl_req_s req,
  input wire lscl_test_s test,
  input wire lscl_event_s evt,
  input wire logic instr_start,
  input wire logic prio_int_req,
  input wire logic [WORD_W-1:0] level_status_word,
  input wire logic transfer_taken,
  input wire logic test_done,
  input wire logic trace_int,
  input wire logic prio_int_grant,
  input wire logic privilege_fault
);
  // ============================================================
  // helpers
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  wire logic hit = evt.class_int || evt.io_int || evt.initial_program_load || evt.sys_reset;
  // the registered store read and the output register lag a level switch by two edges
  logic [LVL_W-1:0] lvl_d1;
  logic [LVL_W-1:0] lvl_d2;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lvl_d1 <= '0;
      lvl_d2 <= '0;
    end else begin
      lvl_d1 <= active_level;
      lvl_d2 <= lvl_d1;
    end
  end
  wire logic lvl_settled = active_level == lvl_d1 && lvl_d1 == lvl_d2;
  wire logic quiet = !req.valid && !hit && lvl_settled;
  wire logic zf = level_status_word[LSCL_BIT_ZERO];
  wire logic smask = level_status_word[LSCL_BIT_SMASK];
  wire logic supv = level_status_word[LSCL_BIT_SUPV];

  // ============================================================
  // chained zero must remember a nonzero low word
  sequence s_low_nonzero;
    req.valid && req.op == LSCL_OP_ADD_WORD && req.opnd_a + req.opnd_b != 16'h0000;
  endsequence
  sequence s_chain_word;
    req.valid && req.op == LSCL_OP_ADD_WORD_WITH_CARRY_IN && !hit;
  endsequence
  property p_chain_zero;
    s_low_nonzero ##1 s_chain_word |=> !zf;
  endproperty
  a_chain_zero: assert property (p_chain_zero) else $error("zero set over nonzero low word");

  property p_test_done;
    test_done == $past(test.valid);
  endproperty
  a_test_done: assert property (p_test_done) else $error("test done pulse misplaced");

  property p_zero_test;
    test.valid && test.cond == LSCL_CC_ZERO && quiet
      |=> transfer_taken == ($past(zf) ^ $past(test.negate));
  endproperty
  a_zero_test: assert property (p_zero_test) else $error("zero condition misjudged");

  property p_trace;
    instr_start && level_status_word[LSCL_BIT_TRACE] && quiet |=> trace_int;
  endproperty
  a_trace: assert property (p_trace) else $error("trace interrupt missing");

  property p_grant;
    quiet |=> prio_int_grant == ($past(prio_int_req) && $past(smask));
  endproperty
  a_grant: assert property (p_grant) else $error("priority grant ignores mask");

  // refused load leaves the word alone
  property p_refuse;
    req.valid && req.op == LSCL_OP_LOAD_LEVEL_BLOCK && !supv && !hit
      |=> privilege_fault && $stable(level_status_word);
  endproperty
  a_refuse: assert property (p_refuse) else $error("problem state load not refused");

  property p_exit;
    req.valid && req.op == LSCL_OP_LEVEL_EXIT && !hit |=> !level_status_word[LSCL_BIT_INPROC];
  endproperty
  a_exit: assert property (p_exit) else $error("in-process kept after exit");

  property p_event;
    hit && evt.level == active_level |=> supv;
  endproperty
  a_event: assert property (p_event) else $error("event left problem state");
endmodule : lscl_status_checker

bind lscl_status lscl_status_checker #(.WORD_W(WORD_W), .LVL_W(LVL_W)) i_chk (
  .clock(clock), .reset_n(reset_n), .active_level(active_level), .req(req), .test(test),
  .evt(evt), .instr_start(instr_start), .prio_int_req(prio_int_req),
  .level_status_word(level_status_word), .transfer_taken(transfer_taken),
  .test_done(test_done), .trace_int(trace_int), .prio_int_grant(prio_int_grant),
  .privilege_fault(privilege_fault)
);

/* File: dv/lscl_seq_model.sv */
// Purpose: stand-in for the sequencer and arithmetic unit
// Assumes: the bench calls these tasks in turn from one process
// Notes: idle inverts opnd_a so stale data never looks live
`timescale 1ns/1ps
module lscl_seq_model
  import lscl_pkg::*;
(
  input wire logic clock,
  output lscl_req_s req,
  output lscl_test_s test,
  output logic instr_start
);
  // ============================================================
  // drivers, all changed just after a rising edge
  initial begin
    req = '0;
    test = '0;
    instr_start = 1'b0;
  end
  task automatic issue(input lscl_req_s r);
    @(posedge clock);
    req <= r;
  endtask : issue
  task automatic probe(input lscl_cond_e c, input logic n, input logic s);
    @(posedge clock);
    test <= '{1'b1, c, n};
    instr_start <= s;
  endtask : probe
  // a gap of n cycles stretches the pace
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      req.valid <= 1'b0;
      req.opnd_a <= ~req.opnd_a;
      test.valid <= 1'b0;
      instr_start <= 1'b0;
    end
  endtask : idle
endmodule : lscl_seq_model

/* File: dv/lscl_status_bench.sv */
// Purpose: self-checking bench for the level status block
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes: a reference word per level is compared at every result
`timescale 1ns/1ps
module lscl_status_bench;
  import lscl_pkg::*;
  logic clock, reset_n, instr_start, prio_int_req, maskable_class_req;
  logic [1:0] active_level;
  lscl_req_s req;
  lscl_test_s test;
  lscl_event_s evt;
  logic [15:0] result, level_status_word, lf, m_res;
  logic transfer_taken, test_done, trace_int, prio_int_grant, maskable_class_grant;
  logic privilege_fault, level_in_process;
  int errors, cmp_count, cycles;
  logic [15:0] mw [4];
  logic [33:0] p0, p1;

  lscl_status i_dut (
    .clock(clock), .reset_n(reset_n), .active_level(active_level), .req(req), .test(test),
    .evt(evt), .instr_start(instr_start), .prio_int_req(prio_int_req),
    .maskable_class_req(maskable_class_req), .result(result),
    .level_status_word(level_status_word), .transfer_taken(transfer_taken),
    .test_done(test_done), .trace_int(trace_int), .prio_int_grant(prio_int_grant),
    .maskable_class_grant(maskable_class_grant), .privilege_fault(privilege_fault),
    .level_in_process(level_in_process)
  );
  lscl_seq_model i_seq (.clock(clock), .req(req), .test(test), .instr_start(instr_start));

  // ============================================================
  // clock, timeout and helpers
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // ============================================================
  // reference model; sub carry is a borrow, so carry-in is inverted
  task automatic send(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] lw = 16'h0, input logic [1:0] tl = 2'h0,
                      input logic [2:0] code = 3'h0);
    logic [15:0] w, bb;
    logic [16:0] r;
    logic ch, sub;
    w = mw[active_level];
    ch = op > 4'h2;
    sub = !op[0];
    bb = (op > 4'h4) ? 16'h0 : b;
    bb = sub ? ~bb : bb;
    r = {1'b0, a} + {1'b0, bb} + {16'h0, sub ^ (ch & w[1])};
    if (op inside {[4'h1:4'h6]}) begin
      w[4] = r[15:0] == 16'h0 && (!ch || w[4]);
      w[3] = r[15];
      w[2] = a[15] == bb[15] && r[15] != a[15];
      w[1] = sub ^ r[16];
      w[0] = ch ? w[0] : !r[0];
      m_res = r[15:0];
    end
    if (op == 4'h7) w[2:0] = {code[0], code[1], code[2]};
    if (op == 4'h9) w[9] = 1'b0;
    mw[active_level] = w;
    if (op == 4'h8 && w[8]) mw[tl] = (mw[tl] & ~LSCL_WRITE_MASK) | (lw & LSCL_WRITE_MASK);
    i_seq.issue('{1'b1, lscl_op_e'(op), a, b, lw, tl, code});
    p0 = {1'b1, op == 4'h8 && !w[8], mw[active_level], m_res};
  endtask : send
  // results land one edge after the request is taken
  always @(negedge clock) begin
    if (p1[33]) begin
      check(result, p1[15:0]);
      check(level_status_word, p1[31:16]);
      check({15'h0, privilege_fault}, {15'h0, p1[32]});
    end
    p1 = p0;
    p0 = '0;
  end
  // every condition in both forms, instruction start on every other condition
  task automatic probe_all();
    logic [15:0] w;
    logic [7:0] ok;
    w = mw[active_level];
    ok = {w[1], w[1] | w[4], (w[3] ^ w[2]) | w[4], w[3] ^ w[2], w[0], w[3], !w[3] && !w[4], w[4]};
    for (int c = 0; c < 16; c++) begin
      i_seq.probe(lscl_cond_e'(c[3:1]), c[0], c[1]);
      i_seq.idle(1);
      #1;
      check({15'h0, transfer_taken}, {15'h0, ok[c[3:1]] ^ c[0]});
      check({14'h0, test_done, trace_int}, {14'h0, 1'b1, c[1] & w[10]});
    end
  endtask : probe_all
  task automatic grants();
    lf = lfsr(lf);
    @(posedge clock);
    prio_int_req <= lf[0];
    maskable_class_req <= lf[1];
    @(posedge clock);
    #1;
    check({13'h0, level_in_process, prio_int_grant, maskable_class_grant},
          {13'h0, mw[active_level][9], {lf[0], lf[1]} & {2{mw[active_level][11]}}});
  endtask : grants
  task automatic hit(input logic [3:0] kind, input logic [1:0] lvl);
    @(posedge clock);
    evt <= {kind, lvl};
    @(posedge clock);
    evt <= '0;
    mw[lvl] = (lvl == active_level) ? (mw[lvl] | 16'h0100) : LSCL_RESET_WORD;
    #1;
    check(level_status_word, mw[active_level]);
  endtask : hit

  // ============================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    active_level = 2'h0;
    evt = '0;
    prio_int_req = 1'b0;
    maskable_class_req = 1'b0;
    {errors, cmp_count, cycles} = '0;
    lf = 16'h662D;  // seed 26157
    {p0, p1, m_res} = '0;
    for (int i = 0; i < 4; i++) mw[i] = LSCL_RESET_WORD;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    i_seq.idle(2);
    #1;
    check(level_status_word, LSCL_RESET_WORD);
    send(4'h8, 16'h0, 16'h0, 16'hFFFF);
    i_seq.idle(1);
    grants();
    probe_all();
    send(4'h8, 16'h0, 16'h0, 16'h0300);
    i_seq.idle(1);
    grants();
    send(4'h9, 16'h0, 16'h0);
    i_seq.idle(1);
    grants();
    // boundary chains: wrap to zero then signed overflow; nonzero low under zero top
    send(4'h1, 16'hFFFF, 16'h0001);
    send(4'h3, 16'h7FFF, 16'h0000);
    send(4'h1, 16'h0001, 16'h0000);
    send(4'h3, 16'h0000, 16'h0000);
    i_seq.idle(1);
    probe_all();
    for (int n = 0; n < 24; n++) begin
      for (int k = 0; k < 3; k++) begin
        lf = lfsr(lf);
        send((k == 0 ? 4'h1 : (k == 2 && lf[3]) ? 4'h5 : 4'h3) + {3'h0, n[0]},
             (lf[5:4] == 2'h0) ? 16'h0 : lf, lf[6] ? {lf[7:0], lf[15:8]} : 16'h0);
      end
      i_seq.idle(1);
      probe_all();
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      send(4'h7, lf, ~lf, lf, lf[1:0], i[2:0]);
    end
    send(4'h8, 16'h0, 16'h0, 16'h0000);
    send(4'h8, 16'h0, 16'h0, 16'h0F1F);
    i_seq.idle(1);
    hit(4'h8, 2'h0);
    send(4'h8, 16'h0, 16'h0, 16'h0A05, 2'h1);
    send(4'h8, 16'h0, 16'h0, 16'h0E1F, 2'h2);
    i_seq.idle(1);
    hit(4'h4, 2'h2);
    hit(4'h2, 2'h3);
    hit(4'h1, 2'h3);
    for (int i = 1; i < 4; i++) begin
      @(posedge clock);
      active_level <= i[1:0];
      i_seq.idle(3);
      #1;
      check(level_status_word, mw[i]);
    end
    give_verdict();
  end
endmodule : lscl_status_bench
